//--- hw/monitor_value_limit_regs.sv
// Register bank of measured values and limits for the hardware monitor.
// Assumes conversion results arrive from logic on sys_clk, one per strobe,
// and that the AXI4-Lite master keeps one read and one write outstanding.
`default_nettype none

module monitor_value_limit_regs
  import monitor_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  // Conversion results from the sequencer on the same clock.
  input wire logic resultValid,
  input wire logic [CH_W-1:0] resultChannel,
  input wire logic [REG_W-1:0] resultData,
  // AXI4-Lite write address channel.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Limits and mode toward the comparison logic, and the interrupt.
  output logic [NUM_LIMITS*REG_W-1:0] limitBus,
  output logic analogInNineSelected,
  output logic eventIrq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Whole state of the block in one record.
  typedef struct packed {
    logic [NUM_RESULTS-1:0][REG_W-1:0] results;
    logic [NUM_LIMITS-1:0][REG_W-1:0] limits;
    logic selectInNine;
    logic [NUM_EVENTS-1:0] eventStatus;
    logic [NUM_EVENTS-1:0] eventEnable;
    logic irq;
    logic awHeld;
    logic [INDEX_W-1:0] awIndex;
    logic wHeld;
    logic [REG_W-1:0] wData;
    logic wLaneLow;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
  } state_t;

  localparam state_t RESET_STATE = '{
    results: {NUM_RESULTS{RESULT_RESET}},
    limits: LIMIT_RESET,
    selectInNine: 1'b0,
    eventStatus: '0,
    eventEnable: '0,
    irq: 1'b0,
    awHeld: 1'b0,
    awIndex: '0,
    wHeld: 1'b0,
    wData: '0,
    wLaneLow: 1'b0,
    awready: 1'b1,
    wready: 1'b1,
    bvalid: 1'b0,
    bresp: RESP_OKAY,
    arready: 1'b1,
    rvalid: 1'b0,
    rresp: RESP_OKAY,
    rdata: '0
  };

  state_t cur;
  state_t next_state;

  ////////////////////////////////////////////////////////////////////////////////
  // Address classification shared by the read and the write path.
  function automatic logic isResult(input logic [INDEX_W-1:0] idx);
    return idx >= IDX_ANALOG_IN3_RESULT && idx <= IDX_TACH7_RESULT;
  endfunction

  function automatic logic isLimit(input logic [INDEX_W-1:0] idx);
    return idx >= IDX_REMOTE_TEMP1_HIGH_LIMIT && idx <= IDX_REMOTE_TEMP1_LOW_LIMIT;
  endfunction

  function automatic logic isControl(input logic [INDEX_W-1:0] idx);
    return idx >= IDX_FUNCTION_CONFIG && idx <= IDX_EVENT_ENABLE;
  endfunction

  // Read value of a word. The event clear register is write-only and reads zero.
  function automatic logic [DATA_W-1:0] readWord(input logic [INDEX_W-1:0] idx,
                                                 input state_t s);
    logic [INDEX_W-1:0] slot;
    logic [DATA_W-1:0] word;
    word = '0;
    slot = '0;
    if (isResult(idx)) begin
      slot = idx - IDX_ANALOG_IN3_RESULT;
      word[REG_W-1:0] = s.results[slot[3:0]];
    end else if (isLimit(idx)) begin
      slot = idx - IDX_REMOTE_TEMP1_HIGH_LIMIT;
      word[REG_W-1:0] = s.limits[slot[3:0]];
    end else if (idx == IDX_FUNCTION_CONFIG) begin
      word[CFG_SEL_IN9_BIT] = s.selectInNine;
    end else if (idx == IDX_EVENT_STATUS) begin
      word[NUM_EVENTS-1:0] = s.eventStatus;
    end else if (idx == IDX_EVENT_ENABLE) begin
      word[NUM_EVENTS-1:0] = s.eventEnable;
    end
    return word;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: conversions, bus write, bus read and events.
  logic [NUM_EVENTS-1:0] eventSet;
  logic [NUM_EVENTS-1:0] eventClr;
  logic [INDEX_W-1:0] wrSlot;
  logic [INDEX_W-1:0] rdIndex;

  always_comb begin
    next_state = cur;
    eventSet = '0;
    eventClr = '0;
    wrSlot = '0;
    rdIndex = s_axi_araddr[ADDR_W-1:INDEX_LSB];

    // A result lands only in the slot of its own channel; others hold.
    if (resultValid) begin
      if (resultChannel < CH_W'(NUM_ANALOG)) begin
        next_state.results[resultChannel] = resultData;
        eventSet[EV_ANALOG_UPDATE] = 1'b1;
      end else if (resultChannel < CH_W'(NUM_RESULTS)) begin
        next_state.results[resultChannel] = resultData;
        eventSet[EV_TACH_UPDATE] = 1'b1;
      end
    end

    // Address and data are captured independently, in either order.
    if (s_axi_awvalid && cur.awready) begin
      next_state.awHeld = 1'b1;
      next_state.awIndex = s_axi_awaddr[ADDR_W-1:INDEX_LSB];
    end
    if (s_axi_wvalid && cur.wready) begin
      next_state.wHeld = 1'b1;
      next_state.wData = s_axi_wdata[REG_W-1:0];
      next_state.wLaneLow = s_axi_wstrb[0];
    end

    // Once both halves are held the write is performed and answered.
    if (cur.awHeld && cur.wHeld && !cur.bvalid) begin
      next_state.awHeld = 1'b0;
      next_state.wHeld = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = RESP_OKAY;
      if (isResult(cur.awIndex)) begin
        // Measured values keep their contents; the attempt is only flagged.
        eventSet[EV_READ_ONLY_WRITE] = 1'b1;
      end else if (isLimit(cur.awIndex)) begin
        wrSlot = cur.awIndex - IDX_REMOTE_TEMP1_HIGH_LIMIT;
        if (cur.wLaneLow) begin
          next_state.limits[wrSlot[3:0]] = cur.wData;
          eventSet[EV_LIMIT_WRITE] = 1'b1;
        end
      end else if (isControl(cur.awIndex)) begin
        if (cur.wLaneLow) begin
          case (cur.awIndex)
            IDX_FUNCTION_CONFIG: begin
              next_state.selectInNine = cur.wData[CFG_SEL_IN9_BIT];
            end
            IDX_EVENT_CLEAR: begin
              eventClr = cur.wData[NUM_EVENTS-1:0];
            end
            IDX_EVENT_ENABLE: begin
              next_state.eventEnable = cur.wData[NUM_EVENTS-1:0];
            end
            default: begin
              next_state.bresp = RESP_OKAY; // Status is read-only; write dropped.
            end
          endcase
        end
      end else begin
        next_state.bresp = RESP_SLVERR;
      end
    end
    if (cur.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end

    // Read answers at the same edge that takes the address.
    if (cur.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    if (s_axi_arvalid && cur.arready) begin
      next_state.rvalid = 1'b1;
      next_state.rdata = readWord(rdIndex, cur);
      if (isResult(rdIndex) || isLimit(rdIndex) || isControl(rdIndex)) begin
        next_state.rresp = RESP_OKAY;
      end else begin
        next_state.rresp = RESP_SLVERR;
      end
    end

    // Ready is withheld while a half is held or an answer is pending,
    // which keeps at most one write and one read in flight.
    next_state.awready = !next_state.awHeld && !next_state.bvalid;
    next_state.wready = !next_state.wHeld && !next_state.bvalid;
    next_state.arready = !next_state.rvalid;

    // A new event in the same cycle as its clear survives the clear.
    next_state.eventStatus = (cur.eventStatus & ~eventClr) | eventSet;
    next_state.irq = |(next_state.eventStatus & next_state.eventEnable);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register with synchronous reset to the power-on values.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur <= RESET_STATE;
    end else begin
      cur <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register.
  assign s_axi_awready = cur.awready;
  assign s_axi_wready = cur.wready;
  assign s_axi_bvalid = cur.bvalid;
  assign s_axi_bresp = cur.bresp;
  assign s_axi_arready = cur.arready;
  assign s_axi_rvalid = cur.rvalid;
  assign s_axi_rdata = cur.rdata;
  assign s_axi_rresp = cur.rresp;
  assign limitBus = cur.limits;
  assign analogInNineSelected = cur.selectInNine;
  assign eventIrq = cur.irq;

endmodule

`default_nettype wire

//--- inc/monitor_regs_pkg.sv
// Constants for the monitor value and limit register bank.
// Assumes one 100 MHz clock domain and a 32-bit AXI4-Lite register bus.
//
// What this block does
// - Five read-only analog input three to seven results at 33h upward, reset 00h.
// - Eight read-only tach channel zero to seven results at 38h-3Fh, reset 00h.
// - Writable remote temp one high limit at 40h, reset 64h (100 C).
// - High limit 41h serves remote temp two or analog in nine; reset 64h.
// - Six writable supply high limits at 42h-47h, each resetting to FFh.
// - Writable remote temp one low limit at 48h, reset 80h.
// - Limits are writable and read back; measured values stay read-only.
`default_nettype none

package monitor_regs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus geometry. Register indices are word numbers; byte address is four times.
  localparam int ADDR_W = 12;
  localparam int INDEX_W = 10;
  localparam int INDEX_LSB = 2;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Measured-value register indices.
  localparam logic [INDEX_W-1:0] IDX_ANALOG_IN3_RESULT = 10'h033;
  localparam logic [INDEX_W-1:0] IDX_ANALOG_IN4_RESULT = 10'h034;
  localparam logic [INDEX_W-1:0] IDX_ANALOG_IN5_RESULT = 10'h035;
  localparam logic [INDEX_W-1:0] IDX_ANALOG_IN6_RESULT = 10'h036;
  localparam logic [INDEX_W-1:0] IDX_ANALOG_IN7_RESULT = 10'h037;
  localparam logic [INDEX_W-1:0] IDX_TACH0_RESULT = 10'h038;
  localparam logic [INDEX_W-1:0] IDX_TACH1_RESULT = 10'h039;
  localparam logic [INDEX_W-1:0] IDX_TACH2_RESULT = 10'h03A;
  localparam logic [INDEX_W-1:0] IDX_TACH3_RESULT = 10'h03B;
  localparam logic [INDEX_W-1:0] IDX_TACH4_RESULT = 10'h03C;
  localparam logic [INDEX_W-1:0] IDX_TACH5_RESULT = 10'h03D;
  localparam logic [INDEX_W-1:0] IDX_TACH6_RESULT = 10'h03E;
  localparam logic [INDEX_W-1:0] IDX_TACH7_RESULT = 10'h03F;

  ////////////////////////////////////////////////////////////////////////////////
  // Limit register indices.
  localparam logic [INDEX_W-1:0] IDX_REMOTE_TEMP1_HIGH_LIMIT = 10'h040;
  localparam logic [INDEX_W-1:0] IDX_REMOTE_TEMP2_OR_IN9_HIGH_LIMIT = 10'h041;
  localparam logic [INDEX_W-1:0] IDX_STANDBY_3V3_HIGH_LIMIT = 10'h042;
  localparam logic [INDEX_W-1:0] IDX_MAIN_3V3_HIGH_LIMIT = 10'h043;
  localparam logic [INDEX_W-1:0] IDX_SUPPLY_5V_HIGH_LIMIT = 10'h044;
  localparam logic [INDEX_W-1:0] IDX_CORE_SUPPLY_HIGH_LIMIT = 10'h045;
  localparam logic [INDEX_W-1:0] IDX_SUPPLY_POS12_HIGH_LIMIT = 10'h046;
  localparam logic [INDEX_W-1:0] IDX_SUPPLY_NEG12_HIGH_LIMIT = 10'h047;
  localparam logic [INDEX_W-1:0] IDX_REMOTE_TEMP1_LOW_LIMIT = 10'h048;

  ////////////////////////////////////////////////////////////////////////////////
  // Control and interrupt register indices.
  localparam logic [INDEX_W-1:0] IDX_FUNCTION_CONFIG = 10'h070;
  localparam logic [INDEX_W-1:0] IDX_EVENT_STATUS = 10'h071;
  localparam logic [INDEX_W-1:0] IDX_EVENT_CLEAR = 10'h072;
  localparam logic [INDEX_W-1:0] IDX_EVENT_ENABLE = 10'h073;

  ////////////////////////////////////////////////////////////////////////////////
  // Slot counts, field positions and reset values.
  localparam int NUM_ANALOG = 5;
  localparam int NUM_RESULTS = 13;
  localparam int NUM_LIMITS = 9;
  localparam int NUM_EVENTS = 4;
  localparam int CH_W = 4;
  localparam int CFG_SEL_IN9_BIT = 0;
  localparam int EV_ANALOG_UPDATE = 0;
  localparam int EV_TACH_UPDATE = 1;
  localparam int EV_READ_ONLY_WRITE = 2;
  localparam int EV_LIMIT_WRITE = 3;
  localparam logic [REG_W-1:0] RESULT_RESET = 8'h00;
  localparam logic [REG_W-1:0] REMOTE_HIGH_RESET = 8'h64;
  localparam logic [REG_W-1:0] SUPPLY_HIGH_RESET = 8'hFF;
  localparam logic [REG_W-1:0] REMOTE_LOW_RESET = 8'h80;
  localparam logic [NUM_LIMITS-1:0][REG_W-1:0] LIMIT_RESET = {
    REMOTE_LOW_RESET,
    SUPPLY_HIGH_RESET, SUPPLY_HIGH_RESET, SUPPLY_HIGH_RESET,
    SUPPLY_HIGH_RESET, SUPPLY_HIGH_RESET, SUPPLY_HIGH_RESET,
    REMOTE_HIGH_RESET, REMOTE_HIGH_RESET
  };

endpackage

`default_nettype wire

//--- bench/monitor_value_limit_regs_chk.sv
// Assertion checker for the monitor value and limit register bank.
// Sees only the bank's top-level ports and is bound to every instance.
`default_nettype none

module monitor_value_limit_regs_chk
  import monitor_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_LIMITS*REG_W-1:0] limitBus
);

  // Both write channels taken at one edge, as the bench always offers them.
  wire logic wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire logic [INDEX_W-1:0] wIdx = s_axi_awaddr[11:2];
  wire logic [INDEX_W-1:0] rIdx = s_axi_araddr[11:2];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////
  // Limits come out of reset at their power-on values.
  a_temp_high_reset: assert property ($past(!rst_n) |-> limitBus[15:0] == 16'h6464)
    else $error("temperature high limits wrong after reset");
  a_supply_high_reset: assert property ($past(!rst_n) |-> limitBus[63:16] == {6{8'hFF}})
    else $error("supply high limits wrong after reset");
  a_temp_low_reset: assert property ($past(!rst_n) |-> limitBus[71:64] == 8'h80)
    else $error("temperature low limit wrong after reset");

  ////////////////////////////////////////
  // A limit write lands in its own slot; slot number is the low index nibble.
  a_limit_written: assert property (wrTake && s_axi_wstrb[0] &&
      wIdx inside {[10'h040:10'h048]} |-> ##2
      limitBus[8*$past(s_axi_awaddr[5:2], 2) +: 8] == $past(s_axi_wdata[7:0], 2))
    else $error("written limit not held");
  a_ro_write_kept: assert property (wrTake && wIdx inside {[10'h033:10'h03F]}
      |=> $stable(limitBus) [*2])
    else $error("measured value write disturbed limits");
  a_write_okay: assert property (wrTake && wIdx inside {[10'h033:10'h048]}
      |-> ##2 s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("bank write not answered okay");
  a_read_okay: assert property (s_axi_arvalid && s_axi_arready &&
      rIdx inside {[10'h033:10'h048]} |=>
      s_axi_rvalid && s_axi_rresp == RESP_OKAY && s_axi_rdata[31:8] == 24'h0)
    else $error("bank read not answered okay");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");

  cover property (wrTake && wIdx == IDX_REMOTE_TEMP1_LOW_LIMIT);
  cover property (wrTake && wIdx == IDX_TACH7_RESULT);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule

bind monitor_value_limit_regs monitor_value_limit_regs_chk chk (.sys_clk, .rst_n,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .limitBus);

`default_nettype wire

//--- bench/tb_monitor_value_limit_regs.sv
// Self-checking bench for the monitor value and limit register bank.
// Drives the register bus and the conversion strobe itself; one clock.
`default_nettype none

module tb_monitor_value_limit_regs
  import monitor_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic resultValid = 1'b0;
  logic [CH_W-1:0] resultChannel = 4'h0;
  logic [REG_W-1:0] resultData = 8'h00;
  logic [ADDR_W-1:0] s_axi_awaddr = 12'h000;
  logic [ADDR_W-1:0] s_axi_araddr = 12'h000;
  logic [DATA_W-1:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [NUM_LIMITS*REG_W-1:0] limitBus;
  logic analogInNineSelected, eventIrq;
  int mismatches = 0;
  int cmpCount = 0;

  // Write response ready stays high; read ready is lowered once to stall an answer.
  monitor_value_limit_regs dut (.sys_clk, .rst_n, .resultValid, .resultChannel, .resultData,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .limitBus,
    .analogInNineSelected, .eventIrq);

  // Free-running 100 MHz clock.
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////
  // Comparison, verdict and bus tasks.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Address and data go out together; each is dropped at the edge it is taken.
  task automatic writeCheck(input logic [INDEX_W-1:0] idx, input logic [31:0] d,
                            input logic [3:0] s);
    int n;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    // A missing answer is a mismatch, so a hang cannot pass on a stale response.
    check("write answer", 32'h1, {31'h0, s_axi_bvalid});
    check("write resp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
  endtask

  task automatic axiRead(input logic [INDEX_W-1:0] idx, output logic [31:0] d,
                         output logic [1:0] r);
    int n;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    check("read answer", 32'h1, {31'h0, s_axi_rvalid});
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic readCheck(input logic [INDEX_W-1:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(idx, d, r);
    check("read data", exp, d);
    check("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  // One conversion strobe, then a quiet cycle so strobes never merge.
  task automatic conv(input logic [CH_W-1:0] ch, input logic [7:0] v);
    resultValid <= 1'b1;
    resultChannel <= ch;
    resultData <= v;
    @(posedge sys_clk);
    resultValid <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic logic [31:0] resetValue(input logic [INDEX_W-1:0] idx);
    if (idx == 10'h048) return 32'h80;
    if (idx >= 10'h042) return 32'hFF;
    if (idx >= 10'h040) return 32'h64;
    return 32'h00;
  endfunction

  ////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [INDEX_W-1:0] x;
    logic [CH_W-1:0] c;
    logic [31:0] d;
    logic [1:0] r;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (x = 10'h033; x <= 10'h048; x++) readCheck(x, resetValue(x));
    $display("reset values done");
    // Upper data bits are junk on purpose; only the low byte may stick.
    for (x = 10'h040; x <= 10'h048; x++) writeCheck(x, {24'hA5A5A5, 8'h90 ^ x[7:0]}, 4'hF);
    for (x = 10'h040; x <= 10'h048; x++) readCheck(x, {24'h0, 8'h90 ^ x[7:0]});
    writeCheck(IDX_REMOTE_TEMP1_HIGH_LIMIT, 32'h11, 4'hE);
    readCheck(IDX_REMOTE_TEMP1_HIGH_LIMIT, 32'hD0);
    $display("limit writes done");
    for (x = 10'h033; x <= 10'h03F; x++) begin
      writeCheck(x, 32'hC3, 4'hF);
      readCheck(x, 32'h0);
    end
    $display("read-only writes done");
    for (c = 4'h0; c <= 4'hC; c++) conv(c, 8'h20 + {4'h0, c});
    conv(4'hD, 8'hEE);
    for (x = 10'h033; x <= 10'h03F; x++) begin
      readCheck(x, {24'h0, 8'h20 + (x[7:0] - 8'h33)});
    end
    conv(4'h5, 8'h7E);
    readCheck(IDX_TACH0_RESULT, 32'h7E);
    readCheck(IDX_TACH1_RESULT, 32'h26);
    // Read ready held low: the answer must stand unchanged until it is taken.
    s_axi_rready <= 1'b0;
    axiRead(IDX_TACH0_RESULT, d, r);
    repeat (3) @(posedge sys_clk);
    check("stalled rvalid", 32'h1, {31'h0, s_axi_rvalid});
    check("stalled data", 32'h7E, s_axi_rdata);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk);
    $display("conversions done");
    writeCheck(IDX_EVENT_ENABLE, 32'h1, 4'hF);
    check("irq raised", 32'h1, {31'h0, eventIrq});
    writeCheck(IDX_EVENT_CLEAR, 32'hF, 4'hF);
    check("irq cleared", 32'h0, {31'h0, eventIrq});
    writeCheck(IDX_EVENT_ENABLE, 32'h0, 4'hF);
    conv(4'h0, 8'h55);
    check("irq masked", 32'h0, {31'h0, eventIrq});
    // A tach update and a refused write add their own status bits.
    conv(4'h6, 8'h26);
    writeCheck(IDX_TACH7_RESULT, 32'h0, 4'hF);
    readCheck(IDX_EVENT_STATUS, 32'h7);
    writeCheck(IDX_EVENT_ENABLE, 32'h1, 4'hF);
    check("irq unmasked", 32'h1, {31'h0, eventIrq});
    writeCheck(IDX_FUNCTION_CONFIG, 32'h1, 4'hF);
    check("nine selected", 32'h1, {31'h0, analogInNineSelected});
    readCheck(IDX_REMOTE_TEMP2_OR_IN9_HIGH_LIMIT, 32'hD1);
    axiRead(10'h100, d, r);
    check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    check("unmapped data", 32'h0, d);
    $display("interrupt and config done");
    printVerdict();
  end

  // Whole run is a few hundred cycles; this limit only cuts a hang short.
  initial begin
    #200000;
    mismatches++;
    printVerdict();
  end

endmodule

`default_nettype wire
